// ===== inc/msi_regs.svh
// Register indexes, field positions and reset values of the soft-iron bank
`ifndef MSI_REGS_SVH
`define MSI_REGS_SVH

// Register indexes; the APB byte address is four times the index
`define MSI_IDX_SI_R1C1_L 8'hc6
`define MSI_IDX_SI_R1C1_H 8'hc7
`define MSI_IDX_SI_R1C2_L 8'hc8
`define MSI_IDX_SI_R1C2_H 8'hc9
`define MSI_IDX_SI_R1C3_L 8'hca
`define MSI_IDX_SI_R1C3_H 8'hcb
`define MSI_IDX_SI_R2C2_L 8'hcc
`define MSI_IDX_SI_R2C2_H 8'hcd
`define MSI_IDX_SI_R2C3_L 8'hce
`define MSI_IDX_SI_R2C3_H 8'hcf
`define MSI_IDX_SI_R3C3_L 8'hd0
`define MSI_IDX_SI_R3C3_H 8'hd1
`define MSI_IDX_ROT_YZ 8'hd4
`define MSI_IDX_ROT_X 8'hd5

// Reset values
`define MSI_RST_ZERO 8'h00
`define MSI_RST_UNITY_HI 8'h3c
`define MSI_RST_ROT_YZ 8'h05
`define MSI_RST_ROT_X 8'h02

// Field positions and writable masks of the rotation registers
`define MSI_Y_SEL_LSB 4
`define MSI_Z_SEL_LSB 0
`define MSI_X_SEL_LSB 0
`define MSI_ROT_YZ_MASK 8'h77
`define MSI_ROT_X_MASK 8'h07

// Axis source codes
`define MSI_SEL_POS_Y 3'h0
`define MSI_SEL_NEG_Y 3'h1
`define MSI_SEL_POS_X 3'h2
`define MSI_SEL_NEG_X 3'h3
`define MSI_SEL_NEG_Z 3'h4
`define MSI_SEL_POS_Z 3'h5

`endif

// ===== inc/msi_pkg.sv
// Types shared by the soft-iron register bank
`default_nettype none
package msi_pkg;

   typedef struct packed {
      logic sign;
      logic [4:0] expo;
      logic [9:0] frac;
   } msi_fp16_s;

   typedef struct packed {
      msi_fp16_s r1c1;
      msi_fp16_s r1c2;
      msi_fp16_s r1c3;
      msi_fp16_s r2c1;
      msi_fp16_s r2c2;
      msi_fp16_s r2c3;
      msi_fp16_s r3c1;
      msi_fp16_s r3c2;
      msi_fp16_s r3c3;
   } msi_matrix_s;

   typedef enum logic [2:0] {
      MSI_AX_X = 3'b001,
      MSI_AX_Y = 3'b010,
      MSI_AX_Z = 3'b100
   } msi_axis_e;

   typedef struct packed {
      logic negate;
      msi_axis_e axis;
   } msi_map_s;

endpackage
`default_nettype wire

// ===== hw/msi_axis_decode.sv
// Decoder from a 3-bit axis source code to a signed axis choice
`timescale 1ns/1ps
`default_nettype none
`include "msi_regs.svh"

module msi_axis_decode (
   input wire logic [2:0] sel_i,
   output msi_pkg::msi_map_s map_o
);

   always_comb begin
      map_o.negate = 1'b0;
      map_o.axis = msi_pkg::MSI_AX_Y;
      case (sel_i)
         `MSI_SEL_NEG_Y: begin
            map_o.negate = 1'b1;
         end
         `MSI_SEL_POS_X: begin
            map_o.axis = msi_pkg::MSI_AX_X;
         end
         `MSI_SEL_NEG_X: begin
            map_o.negate = 1'b1;
            map_o.axis = msi_pkg::MSI_AX_X;
         end
         `MSI_SEL_NEG_Z: begin
            map_o.negate = 1'b1;
            map_o.axis = msi_pkg::MSI_AX_Z;
         end
         `MSI_SEL_POS_Z: begin
            map_o.axis = msi_pkg::MSI_AX_Z;
         end
         // Unused codes fall back to plus Y
         default: begin
         end
      endcase
   end

endmodule
`default_nettype wire

// ===== hw/msi_regs_top.sv
// APB register bank for magnetometer soft-iron matrix and axis remap
`timescale 1ns/1ps
`default_nettype none
`include "msi_regs.svh"

// How it works
// - Coefficients are half floats: sign, exponent, fraction
// - Coefficient low byte even, high byte odd
// - Row1col3 value also feeds row3col1
// - Row2col3 value also feeds row3col2
// - Row2col2, row3col3 reset to unity 0x3c00
// - Off-diagonal row1col3, row2col3 reset to zero
// - Y selector bits 6:4, reset plus Y
// - Z selector bits 2:0, reset plus Z
// - X selector bits 2:0, reset plus X
// - Row1col1 high byte resets to 0x3c
// - Row1col2 value also feeds row2col1
module msi_regs_top #(
   parameter int ADDR_W = 12
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   output msi_pkg::msi_matrix_s coef_o,
   output msi_pkg::msi_map_s x_map_o,
   output msi_pkg::msi_map_s y_map_o,
   output msi_pkg::msi_map_s z_map_o
);

   localparam int NB = 12;
   localparam logic [7:0] SI_RST [NB] = '{
      `MSI_RST_ZERO, `MSI_RST_UNITY_HI,
      `MSI_RST_ZERO, `MSI_RST_ZERO,
      `MSI_RST_ZERO, `MSI_RST_ZERO,
      `MSI_RST_ZERO, `MSI_RST_UNITY_HI,
      `MSI_RST_ZERO, `MSI_RST_ZERO,
      `MSI_RST_ZERO, `MSI_RST_UNITY_HI};
   localparam msi_pkg::msi_map_s MAP_RST [3] = '{
      '{negate: 1'b0, axis: msi_pkg::MSI_AX_X},
      '{negate: 1'b0, axis: msi_pkg::MSI_AX_Y},
      '{negate: 1'b0, axis: msi_pkg::MSI_AX_Z}};

   // Index D5 needs ten address bits
   generate
      if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_width
         $error("msi_regs_top: ADDR_W must be 10 to 32");
      end
   endgenerate

   logic [7:0] si_byte [NB];
   logic [7:0] rot_yz;
   logic [7:0] rot_x;
   msi_pkg::msi_map_s map_q [3];
   logic [2:0] sel_code [3];
   msi_pkg::msi_map_s map_dec [3];
   logic [15:0] coef_word [6];

   logic [ADDR_W-3:0] idx;
   logic setup;
   logic access;
   logic wr_en;
   logic hit_si;
   logic hit_yz;
   logic hit_x;
   logic [3:0] si_sel;
   logic [7:0] rd_byte;
   logic [ADDR_W-3:0] rel;

   assign idx = paddr_i[ADDR_W-1:2];
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i & pready_o;
   // Lane 0 carries the byte; other lanes are ignored
   assign wr_en = access & pwrite_i & pstrb_i[0];
   assign rel = idx - (ADDR_W-2)'(`MSI_IDX_SI_R1C1_L);

   // Address decode; misaligned byte addresses never hit
   always_comb begin
      hit_si = 1'b0;
      hit_yz = 1'b0;
      hit_x = 1'b0;
      si_sel = 4'h0;
      if (paddr_i[1:0] != 2'b00) begin
         hit_si = 1'b0;
      end else if (idx >= (ADDR_W-2)'(`MSI_IDX_SI_R1C1_L) &&
                   idx <= (ADDR_W-2)'(`MSI_IDX_SI_R3C3_H)) begin
         hit_si = 1'b1;
         si_sel = rel[3:0];
      end else if (idx == (ADDR_W-2)'(`MSI_IDX_ROT_YZ)) begin
         hit_yz = 1'b1;
      end else if (idx == (ADDR_W-2)'(`MSI_IDX_ROT_X)) begin
         hit_x = 1'b1;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      if (hit_si) begin
         rd_byte = si_byte[si_sel];
      end else if (hit_yz) begin
         rd_byte = rot_yz;
      end else if (hit_x) begin
         rd_byte = rot_x;
      end
   end

   // Coefficient byte storage, one register per byte
   generate
      for (genvar i = 0; i < NB; i++) begin : g_si
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               si_byte[i] <= SI_RST[i];
            end else if (wr_en && hit_si && si_sel == 4'(i)) begin
               si_byte[i] <= pwdata_i[7:0];
            end
         end
      end
      for (genvar k = 0; k < 6; k++) begin : g_word
         assign coef_word[k] = {si_byte[2*k+1], si_byte[2*k]};
      end
   endgenerate

   // Each word is a half float: sign, exponent, fraction
   assign coef_o.r1c1 = coef_word[0];
   assign coef_o.r1c2 = coef_word[1];
   assign coef_o.r2c1 = coef_word[1];
   assign coef_o.r1c3 = coef_word[2];
   assign coef_o.r3c1 = coef_word[2];
   assign coef_o.r2c2 = coef_word[3];
   assign coef_o.r2c3 = coef_word[4];
   assign coef_o.r3c2 = coef_word[4];
   assign coef_o.r3c3 = coef_word[5];

   // Unused bits are not stored and read back as zero
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rot_yz <= `MSI_RST_ROT_YZ;
      end else if (wr_en && hit_yz) begin
         rot_yz <= pwdata_i[7:0] & `MSI_ROT_YZ_MASK;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rot_x <= `MSI_RST_ROT_X;
      end else if (wr_en && hit_x) begin
         rot_x <= pwdata_i[7:0] & `MSI_ROT_X_MASK;
      end
   end

   assign sel_code[0] = rot_x[`MSI_X_SEL_LSB +: 3];
   assign sel_code[1] = rot_yz[`MSI_Y_SEL_LSB +: 3];
   assign sel_code[2] = rot_yz[`MSI_Z_SEL_LSB +: 3];

   // Decoded choice registered so the datapath sees a flop
   generate
      for (genvar a = 0; a < 3; a++) begin : g_axis
         msi_axis_decode u_dec (
            .sel_i(sel_code[a]),
            .map_o(map_dec[a])
         );
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               map_q[a] <= MAP_RST[a];
            end else begin
               map_q[a] <= map_dec[a];
            end
         end
      end
   endgenerate

   assign x_map_o = map_q[0];
   assign y_map_o = map_q[1];
   assign z_map_o = map_q[2];

   // Zero wait states: ready rises for exactly the access phase
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= setup;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (setup) begin
         prdata_o <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= setup & ~(hit_si | hit_yz | hit_x);
      end
   end

   // First cycle after reset release, for the reset checks
   logic past_reset;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         past_reset <= 1'b0;
      end else begin
         past_reset <= 1'b1;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   fp16_fields_a:
   assert property (coef_o.r2c2.sign == si_byte[7][7] &&
                    coef_o.r2c2.expo == si_byte[7][6:2] &&
                    coef_o.r2c2.frac == {si_byte[7][1:0], si_byte[6]})
   else $error("half float fields misplaced");

   byte_write_a:
   assert property (wr_en && idx == (ADDR_W-2)'(`MSI_IDX_SI_R2C3_H) &&
                    paddr_i[1:0] == 2'b00
                    |=> coef_o.r2c3[15:8] == $past(pwdata_i[7:0]))
   else $error("high byte write not seen at odd index");

   low_byte_write_a:
   assert property (wr_en && idx == (ADDR_W-2)'(`MSI_IDX_SI_R1C3_L) &&
                    paddr_i[1:0] == 2'b00
                    |=> coef_o.r1c3[7:0] == $past(pwdata_i[7:0]) &&
                        $stable(coef_o.r1c3[15:8]))
   else $error("low byte write not seen at even index");

   sym_r13_a:
   assert property (coef_o.r3c1 == coef_o.r1c3)
   else $error("row3col1 differs from row1col3");

   sym_r23_a:
   assert property (coef_o.r3c2 == coef_o.r2c3)
   else $error("row3col2 differs from row2col3");

   sym_r12_a:
   assert property (coef_o.r2c1 == coef_o.r1c2)
   else $error("row2col1 differs from row1col2");

   diag_reset_a:
   assert property (!past_reset |-> coef_o.r2c2 == 16'h3c00 &&
                    coef_o.r3c3 == 16'h3c00)
   else $error("diagonal not unity after reset");

   offdiag_reset_a:
   assert property (!past_reset |-> coef_o.r1c3 == 16'h0000 &&
                    coef_o.r2c3 == 16'h0000)
   else $error("off diagonal not zero after reset");

   r1c1_reset_a:
   assert property (!past_reset |-> coef_o.r1c1[15:8] == 8'h3c)
   else $error("row1col1 high byte not 0x3c after reset");

   y_select_a:
   assert property (sel_code[1] == 3'h4 |=> y_map_o.negate &&
                    y_map_o.axis == msi_pkg::MSI_AX_Z)
   else $error("Y code 100 not minus Z");

   z_select_a:
   assert property (sel_code[2] == 3'h3 |=> z_map_o.negate &&
                    z_map_o.axis == msi_pkg::MSI_AX_X)
   else $error("Z code 011 not minus X");

   x_select_a:
   assert property (sel_code[0] inside {3'h6, 3'h7} |=> !x_map_o.negate &&
                    x_map_o.axis == msi_pkg::MSI_AX_Y)
   else $error("X spare code not plus Y");

   axis_reset_a:
   assert property (!past_reset |-> x_map_o.axis == msi_pkg::MSI_AX_X &&
                    y_map_o.axis == msi_pkg::MSI_AX_Y &&
                    z_map_o.axis == msi_pkg::MSI_AX_Z)
   else $error("axis map wrong after reset");

   spare_bits_a:
   assert property (setup && hit_yz |=> prdata_o[7] == 1'b0 &&
                    prdata_o[3] == 1'b0)
   else $error("unused rotation bits read nonzero");

   coef_stable_a:
   assert property (!(wr_en && hit_si) |=> $stable(coef_o))
   else $error("coefficient moved without a write");

   ready_pulse_a:
   assert property (setup |=> pready_o ##1 !pready_o)
   else $error("ready not a single access cycle");

endmodule
`default_nettype wire

// ===== verification/msi_regs_tb.sv
// Self-checking testbench for the soft-iron register bank
`timescale 1ns/1ps
`default_nettype none
`include "msi_regs.svh"

module testbench;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [3:0] pstrb_i = 4'h0;
   logic pready_o;
   logic [31:0] prdata_o;
   logic pslverr_o;
   msi_pkg::msi_matrix_s coef_o;
   msi_pkg::msi_map_s x_map_o;
   msi_pkg::msi_map_s y_map_o;
   msi_pkg::msi_map_s z_map_o;
   int num_errors = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic err;
   logic [7:0] rst_tab [14] = '{8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h05, 8'h02};

   always #5 mclk_i = ~mclk_i;

   msi_regs_top #(.ADDR_W(12)) i_msi_regs_top (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i),
      .pready_o(pready_o),
      .prdata_o(prdata_o),
      .pslverr_o(pslverr_o),
      .coef_o(coef_o),
      .x_map_o(x_map_o),
      .y_map_o(y_map_o),
      .z_map_o(z_map_o)
   );

   task automatic complete_run();
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check_val(input string n, input logic [31:0] e,
                            input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_map(input string n, input msi_pkg::msi_map_s e,
                            input msi_pkg::msi_map_s g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] addr,
                      input logic [7:0] wd, input logic [3:0] strb);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= {24'hdead_be, wd};
      pstrb_i <= strb;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) begin
         check_val("pready_timeout", 32'h0000_0001, {31'h0, pready_o});
         complete_run();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   function automatic logic [7:0] idx_of(input int k);
      return (k < 12) ? 8'(`MSI_IDX_SI_R1C1_L + k) : 8'(`MSI_IDX_ROT_YZ + k - 12);
   endfunction

   function automatic msi_pkg::msi_map_s exp_map(input logic [2:0] c);
      msi_pkg::msi_map_s m;
      m.negate = (c == 3'h1) || (c == 3'h3) || (c == 3'h4);
      case (c)
         3'h2, 3'h3: m.axis = msi_pkg::MSI_AX_X;
         3'h4, 3'h5: m.axis = msi_pkg::MSI_AX_Z;
         default: m.axis = msi_pkg::MSI_AX_Y;
      endcase
      return m;
   endfunction

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {2'b00, idx, 2'b00}, d, 4'h1);
   endtask

   task automatic rdc(input string n, input logic [7:0] idx,
                      input logic [7:0] e);
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, 4'h0);
      check_val(n, {24'h00_0000, e}, rd);
      check_val("pslverr", 32'h0000_0000, {31'h0, err});
   endtask

   // Words packed r1c1, r1c2, r1c3, r2c2, r2c3, r3c3
   task automatic check_coef(input logic [95:0] w);
      check_val("r1c1", {16'h0, w[95:80]}, {16'h0, coef_o.r1c1});
      check_val("r1c2", {16'h0, w[79:64]}, {16'h0, coef_o.r1c2});
      check_val("r2c1", {16'h0, w[79:64]}, {16'h0, coef_o.r2c1});
      check_val("r1c3", {16'h0, w[63:48]}, {16'h0, coef_o.r1c3});
      check_val("r3c1", {16'h0, w[63:48]}, {16'h0, coef_o.r3c1});
      check_val("r2c2", {16'h0, w[47:32]}, {16'h0, coef_o.r2c2});
      check_val("r2c3", {16'h0, w[31:16]}, {16'h0, coef_o.r2c3});
      check_val("r3c2", {16'h0, w[31:16]}, {16'h0, coef_o.r3c2});
      check_val("r3c3", {16'h0, w[15:0]}, {16'h0, coef_o.r3c3});
   endtask

   task automatic reset_check();
      for (int k = 0; k < 14; k++) begin
         rdc("reset_value", idx_of(k), rst_tab[k]);
      end
      check_coef(96'h3c00_0000_0000_3c00_0000_3c00);
      check_map("x_map", exp_map(3'h2), x_map_o);
      check_map("y_map", exp_map(3'h0), y_map_o);
      check_map("z_map", exp_map(3'h5), z_map_o);
   endtask

   task automatic t_coef();
      for (int k = 0; k < 12; k++) begin
         wr(idx_of(k), 8'(8'ha0 + k));
         #1;
         if (k == 8) begin
            check_val("r3c2_half", 32'h0000_00a8, {16'h0, coef_o.r3c2});
         end
      end
      for (int k = 0; k < 12; k++) begin
         rdc("readback", idx_of(k), 8'(8'ha0 + k));
      end
      check_coef(96'ha1a0_a3a2_a5a4_a7a6_a9a8_abaa);
      check_val("sign", 32'h0000_0001, {31'h0, coef_o.r3c3.sign});
      check_val("expo", 32'h0000_000a, {27'h0, coef_o.r3c3.expo});
      check_val("frac", 32'h0000_03aa, {22'h0, coef_o.r3c3.frac});
   endtask

   // Refused accesses leave every coefficient as it was
   task automatic t_err();
      apb(1'b1, {2'b00, `MSI_IDX_SI_R2C2_L, 2'b00}, 8'h55, 4'h0);
      check_val("strb_err", 32'h0000_0000, {31'h0, err});
      apb(1'b1, {2'b00, 8'hd2, 2'b00}, 8'h55, 4'h1);
      check_val("unmapped_err", 32'h0000_0001, {31'h0, err});
      apb(1'b0, {2'b00, 8'hd2, 2'b00}, 8'h00, 4'h0);
      check_val("unmapped_data", 32'h0000_0000, rd);
      apb(1'b1, {2'b00, `MSI_IDX_SI_R1C1_L, 2'b01}, 8'h55, 4'h1);
      check_val("misaligned_err", 32'h0000_0001, {31'h0, err});
      #1;
      check_coef(96'ha1a0_a3a2_a5a4_a7a6_a9a8_abaa);
   endtask

   task automatic t_maps();
      logic [2:0] y;
      logic [2:0] z;
      logic [2:0] x;
      for (int c = 0; c < 8; c++) begin
         y = 3'(c);
         z = 3'(c + 3);
         x = 3'(c + 5);
         wr(`MSI_IDX_ROT_YZ, {1'b0, y, 1'b0, z});
         wr(`MSI_IDX_ROT_X, {5'h00, x});
         @(posedge mclk_i);
         #1;
         check_map("y_map", exp_map(y), y_map_o);
         check_map("z_map", exp_map(z), z_map_o);
         check_map("x_map", exp_map(x), x_map_o);
         rdc("rot_yz", `MSI_IDX_ROT_YZ, {1'b0, y, 1'b0, z});
         rdc("rot_x", `MSI_IDX_ROT_X, {5'h00, x});
      end
   endtask

   initial begin
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      reset_check();
      t_coef();
      t_err();
      t_maps();
      // Second reset in mid-run must restore every default
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      reset_check();
      complete_run();
   end
endmodule
`default_nettype wire
